// *** rtl/lsbe_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: Post-increment load reads at pointer, then pointer plus one; two cycles, flags kept.
// RULE2: Pre-decrement load lowers pointer first, then reads at new value; two cycles.
// RULE3: Displaced load reads at Y or Z plus offset, pointer kept; two cycles.
// RULE4: Direct load reads the immediate data address into a register; two cycles.
// RULE5: Post-increment store writes at pointer, then pointer plus one; two cycles.
// RULE6: Pre-decrement store lowers pointer first, then writes there; two cycles.
// RULE7: Displaced store writes at Y or Z plus offset, pointer kept; two cycles.
// RULE8: Direct store writes the register at immediate address; two cycles, flags kept.
// RULE9: Push writes a register onto the stack in two cycles, flags kept.
// RULE10: Pop loads a register from the stack in two cycles, flags kept.
// RULE11: I/O bit set forces one port bit to one in two cycles.
// RULE12: I/O bit clear forces one port bit to zero in two cycles.
// RULE13: Rotate left through carry, updating Z, C, N and V in one cycle.
// RULE14: Rotate right through carry, updating Z, C, N and V in one cycle.
// RULE15: Copy a chosen register bit into T in one cycle.
// RULE16: Copy T into a chosen register bit in one cycle, flags kept.
// RULE17: Set or clear V alone in one cycle.
// RULE18: Set or clear H alone in one cycle.
// RULE19: Set or clear S alone in one cycle.
// RULE20: Program memory read with post-increment is refused and flagged.
// RULE21: X, Y, Z are fixed register pairs; updates carry over all 16 bits.
// RULE22: Arithmetic right shift keeps bit 7, bit 0 goes to carry, one cycle.
module lsbe_exec
  import lsbe_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Operation request.
  input  wire logic        op_valid,
  input  wire lsbe_op_type op_code,
  input  wire logic [4:0]  op_reg,
  input  wire logic [1:0]  op_ptr,
  input  wire logic [5:0]  op_disp,
  input  wire logic [15:0] op_addr,
  input  wire logic [2:0]  op_bit,
  input  wire logic [5:0]  op_io,
  output logic             op_ready,
  output logic             op_error,
  // Data memory.
  input  wire logic [7:0]  mem_rdata,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  // I/O space with bit mask.
  output logic [5:0]       io_addr,
  output logic [7:0]       io_wdata,
  output logic [7:0]       io_wmask,
  output logic             io_we,
  // Software port.
  input  wire logic [7:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_write,
  input  wire logic        sw_read,
  output logic [7:0]       sw_rdata
);

  // ----------------------------------------
  // State.
  // ----------------------------------------
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic [7:0]               flags;
    logic [15:0]              sp;
    logic                     enable;
    logic                     err;
    logic                     ready;
    lsbe_state_type           state;
    logic                     load;
    logic [4:0]               dst;
    logic [15:0]              mem_addr;
    logic [7:0]               mem_wdata;
    logic                     mem_we;
    logic                     mem_re;
    logic [5:0]               io_addr;
    logic [7:0]               io_wdata;
    logic [7:0]               io_wmask;
    logic                     io_we;
    logic [7:0]               sw_rdata;
  } lsbe_s_type;

  lsbe_s_type s_q;
  lsbe_s_type s_d;

  logic        accept;
  logic [4:0]  plo;
  logic [4:0]  phi;
  logic [15:0] pval;
  logic [15:0] pinc;
  logic [15:0] pdec;
  logic [15:0] pdisp;
  logic [7:0]  rv;
  logic [7:0]  bmask;

  // ----------------------------------------
  // Pointer pair and operand views.
  // ----------------------------------------
  assign accept = op_valid && s_q.ready && s_q.enable;
  assign plo    = PTR_X_LOW + {2'b00, op_ptr, 1'b0};  // [RULE21]
  assign phi    = plo | PAIR_HIGH;  // [RULE21]
  assign pval   = {s_q.regs[phi], s_q.regs[plo]};
  assign pinc   = pval + PTR_STEP;  // [RULE21]
  assign pdec   = pval - PTR_STEP;  // [RULE21]
  assign pdisp  = pval + {10'h000, op_disp};
  assign rv     = s_q.regs[op_reg];
  assign bmask  = 8'h01 << op_bit;

  // ----------------------------------------
  // Next state.
  // ----------------------------------------
  always_comb
  begin
    logic [7:0]  res;
    logic [15:0] newp;
    logic        wrp;
    res  = rv;
    newp = pval;
    wrp  = 1'b0;
    s_d  = s_q;
    s_d.mem_we   = 1'b0;
    s_d.mem_re   = 1'b0;
    s_d.io_we    = 1'b0;
    s_d.sw_rdata = 8'h00;
    if (sw_read)
    begin
      if (sw_addr <= OFS_GPR_LAST)
        s_d.sw_rdata = s_q.regs[sw_addr[4:0]];
      else if (sw_addr == OFS_FLAGS)
        s_d.sw_rdata = s_q.flags;
      else if (sw_addr == OFS_SP_LO)
        s_d.sw_rdata = s_q.sp[7:0];
      else if (sw_addr == OFS_SP_HI)
        s_d.sw_rdata = s_q.sp[15:8];
      else if (sw_addr == OFS_STATUS)
      begin
        s_d.sw_rdata[STAT_BUSY] = ~s_q.ready;
        s_d.sw_rdata[STAT_ERR]  = s_q.err;
      end
      else if (sw_addr == OFS_CTRL)
        s_d.sw_rdata[CTRL_EN] = s_q.enable;
    end
    if (sw_write)
    begin
      if (sw_addr <= OFS_GPR_LAST)
        s_d.regs[sw_addr[4:0]] = sw_wdata;
      else if (sw_addr == OFS_FLAGS)
        s_d.flags = sw_wdata;
      else if (sw_addr == OFS_SP_LO)
        s_d.sp[7:0] = sw_wdata;
      else if (sw_addr == OFS_SP_HI)
        s_d.sp[15:8] = sw_wdata;
      else if (sw_addr == OFS_STATUS && sw_wdata[STAT_ERR])
        s_d.err = 1'b0;
      else if (sw_addr == OFS_CTRL)
        s_d.enable = sw_wdata[CTRL_EN];
    end
    case (s_q.state)
      ST_IDLE:
      begin
        if (accept)
        begin
          s_d.dst  = op_reg;
          s_d.load = 1'b0;
          case (op_code)
            OP_IND_RD, OP_IND_RD_I, OP_IND_RD_D, OP_DISP_RD, OP_DIR_RD, OP_POP:
            begin
              s_d.mem_re = 1'b1;
              s_d.load   = 1'b1;
              s_d.state  = ST_MEM;
              s_d.mem_addr = pval;
              if (op_code == OP_IND_RD_I)
              begin
                newp = pinc;  // [RULE1]
                wrp  = 1'b1;
              end
              else if (op_code == OP_IND_RD_D)
              begin
                newp = pdec;  // [RULE2]
                wrp  = 1'b1;
                s_d.mem_addr = pdec;
              end
              else if (op_code == OP_DISP_RD)
                s_d.mem_addr = pdisp;  // [RULE3]
              else if (op_code == OP_DIR_RD)
                s_d.mem_addr = op_addr;  // [RULE4]
              else if (op_code == OP_POP)
              begin
                s_d.sp       = s_q.sp + PTR_STEP;  // [RULE10]
                s_d.mem_addr = s_q.sp + PTR_STEP;
              end
            end
            OP_IND_WR, OP_IND_WR_I, OP_IND_WR_D, OP_DISP_WR, OP_DIR_WR, OP_PUSH:
            begin
              s_d.mem_we    = 1'b1;
              s_d.mem_wdata = rv;
              s_d.state     = ST_MEM;
              s_d.mem_addr  = pval;
              if (op_code == OP_IND_WR_I)
              begin
                newp = pinc;  // [RULE5]
                wrp  = 1'b1;
              end
              else if (op_code == OP_IND_WR_D)
              begin
                newp = pdec;  // [RULE6]
                wrp  = 1'b1;
                s_d.mem_addr = pdec;
              end
              else if (op_code == OP_DISP_WR)
                s_d.mem_addr = pdisp;  // [RULE7]
              else if (op_code == OP_DIR_WR)
                s_d.mem_addr = op_addr;  // [RULE8]
              else if (op_code == OP_PUSH)
              begin
                s_d.mem_addr = s_q.sp;  // [RULE9]
                s_d.sp       = s_q.sp - PTR_STEP;
              end
            end
            OP_IO_SET, OP_IO_CLR:
            begin
              s_d.io_we    = 1'b1;
              s_d.io_addr  = op_io;
              s_d.io_wmask = bmask;
              s_d.io_wdata = (op_code == OP_IO_SET) ? bmask : 8'h00;  // [RULE11] [RULE12]
              s_d.state    = ST_MEM;
            end
            OP_ROT_L:
            begin
              res = {rv[6:0], s_q.flags[FLAG_C]};  // [RULE13]
              s_d.flags[FLAG_C] = rv[7];
            end
            OP_ROT_R:
            begin
              res = {s_q.flags[FLAG_C], rv[7:1]};  // [RULE14]
              s_d.flags[FLAG_C] = rv[0];
            end
            OP_ASH_R:
            begin
              res = {rv[7], rv[7:1]};  // [RULE22]
              s_d.flags[FLAG_C] = rv[0];
            end
            OP_BIT_TO_T: s_d.flags[FLAG_T] = rv[op_bit];  // [RULE15]
            OP_T_TO_BIT: s_d.regs[op_reg][op_bit] = s_q.flags[FLAG_T];  // [RULE16]
            OP_V_SET:    s_d.flags[FLAG_V] = 1'b1;  // [RULE17]
            OP_V_CLR:    s_d.flags[FLAG_V] = 1'b0;  // [RULE17]
            OP_H_SET:    s_d.flags[FLAG_H] = 1'b1;  // [RULE18]
            OP_H_CLR:    s_d.flags[FLAG_H] = 1'b0;  // [RULE18]
            OP_S_SET:    s_d.flags[FLAG_S] = 1'b1;  // [RULE19]
            OP_S_CLR:    s_d.flags[FLAG_S] = 1'b0;  // [RULE19]
            OP_PMR_INC:  s_d.err = 1'b1;  // [RULE20]
            default:     s_d.err = s_d.err;
          endcase
          if (op_code == OP_ROT_L || op_code == OP_ROT_R || op_code == OP_ASH_R)
          begin
            s_d.regs[op_reg]  = res;
            s_d.flags[FLAG_Z] = (res == 8'h00);
            s_d.flags[FLAG_N] = res[7];
            s_d.flags[FLAG_V] = res[7] ^ s_d.flags[FLAG_C];
          end
          if (wrp)
          begin
            s_d.regs[plo] = newp[7:0];  // [RULE21]
            s_d.regs[phi] = newp[15:8];
          end
        end
      end
      ST_MEM:
      begin
        if (s_q.load)
          s_d.regs[s_q.dst] = mem_rdata;  // [RULE1] [RULE2] [RULE3] [RULE4] [RULE10]
        s_d.state = ST_IDLE;
      end
      default: s_d.state = ST_IDLE;
    endcase
    s_d.ready = (s_d.state == ST_IDLE);
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q        <= '0;
      s_q.flags  <= FLAGS_RESET;
      s_q.sp     <= SP_RESET;
      s_q.enable <= 1'b1;
      s_q.ready  <= 1'b1;
      s_q.state  <= ST_IDLE;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  assign op_ready  = s_q.ready;
  assign op_error  = s_q.err;
  assign mem_addr  = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign mem_we    = s_q.mem_we;
  assign mem_re    = s_q.mem_re;
  assign io_addr   = s_q.io_addr;
  assign io_wdata  = s_q.io_wdata;
  assign io_wmask  = s_q.io_wmask;
  assign io_we     = s_q.io_we;
  assign sw_rdata  = s_q.sw_rdata;

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence mem_slot;
    !op_ready ##1 op_ready;
  endsequence

  sequence acc_op(lsbe_op_type c);
    accept && op_code == c && !sw_write;
  endsequence

  postinc_read_a: assert property (acc_op(OP_IND_RD_I) |=> mem_re && mem_addr == $past(pval) && pval == $past(pinc) ##0 mem_slot) // [RULE1]
    else $error("post-increment load wrong");
  postinc_ptr_a: assert property (acc_op(OP_IND_RD_I) ##1 1 |-> {s_q.regs[$past(phi)], s_q.regs[$past(plo)]} == $past(pinc)) // [RULE1]
    else $error("pointer not incremented");
  predec_read_a: assert property (acc_op(OP_IND_RD_D) |=> mem_re && mem_addr == $past(pdec) ##0 mem_slot) // [RULE2]
    else $error("pre-decrement load wrong");
  disp_keep_a: assert property (acc_op(OP_DISP_RD) |=> mem_addr == $past(pdisp) && s_q.regs == $past(s_q.regs)) // [RULE3]
    else $error("displaced load wrong");
  load_wb_a: assert property (s_q.state == ST_MEM && s_q.load && !sw_write |=> s_q.regs[$past(s_q.dst)] == $past(mem_rdata)) // [RULE4]
    else $error("load data not written back");
  direct_wr_a: assert property (acc_op(OP_DIR_WR) |=> mem_we && mem_addr == $past(op_addr) && s_q.flags == $past(s_q.flags) ##1 !mem_we) // [RULE8]
    else $error("direct store wrong");
  predec_wr_a: assert property (acc_op(OP_IND_WR_D) |=> mem_we && mem_addr == $past(pdec) && mem_wdata == $past(rv)) // [RULE6]
    else $error("pre-decrement store wrong");
  push_sp_a: assert property (acc_op(OP_PUSH) |=> mem_we && mem_addr == $past(s_q.sp) && s_q.sp == $past(s_q.sp) - PTR_STEP) // [RULE9]
    else $error("push stack wrong");
  io_bit_a: assert property (acc_op(OP_IO_CLR) |=> io_we && io_wdata == 8'h00 && io_wmask == $past(bmask) ##1 !io_we) // [RULE12]
    else $error("io bit clear wrong");
  rotate_l_a: assert property (acc_op(OP_ROT_L) |=> s_q.flags[FLAG_C] == $past(rv[7]) && op_ready) // [RULE13]
    else $error("rotate left carry wrong");
  flag_v_a: assert property (acc_op(OP_V_SET) |=> s_q.flags == ($past(s_q.flags) | 8'h08)) // [RULE17]
    else $error("overflow set wrong");
  refuse_a: assert property (acc_op(OP_PMR_INC) |=> op_error && op_ready && !mem_re) // [RULE20]
    else $error("refused op not flagged");

endmodule // lsbe_exec
`default_nettype wire

// *** rtl/lsbe_pkg.sv ***
package lsbe_pkg;

  // ----------------------------------------
  // Sizes and register offsets.
  // ----------------------------------------
  localparam int         NUM_REGS      = 32;
  localparam logic [7:0] OFS_GPR_LAST  = 8'h1f;
  localparam logic [7:0] OFS_FLAGS     = 8'h20;
  localparam logic [7:0] OFS_SP_LO     = 8'h21;
  localparam logic [7:0] OFS_SP_HI     = 8'h22;
  localparam logic [7:0] OFS_STATUS    = 8'h23;
  localparam logic [7:0] OFS_CTRL      = 8'h24;
  localparam int         STAT_BUSY     = 0;
  localparam int         STAT_ERR      = 1;
  localparam int         CTRL_EN       = 0;

  // ----------------------------------------
  // Flag positions and reset values.
  // ----------------------------------------
  localparam int          FLAG_C       = 0;
  localparam int          FLAG_Z       = 1;
  localparam int          FLAG_N       = 2;
  localparam int          FLAG_V       = 3;
  localparam int          FLAG_S       = 4;
  localparam int          FLAG_H       = 5;
  localparam int          FLAG_T       = 6;
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam logic [15:0] SP_RESET     = 16'h007f;
  localparam logic [15:0] PTR_STEP     = 16'h0001;
  localparam logic [4:0]  PTR_X_LOW    = 5'h1a;
  localparam logic [4:0]  PAIR_HIGH    = 5'h01;

  // ----------------------------------------
  // Operations, pointer choice and states.
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_NOP      = 5'b00000,
    OP_IND_RD   = 5'b00001,
    OP_IND_RD_I = 5'b00010,
    OP_IND_RD_D = 5'b00011,
    OP_DISP_RD  = 5'b00100,
    OP_DIR_RD   = 5'b00101,
    OP_IND_WR   = 5'b00110,
    OP_IND_WR_I = 5'b00111,
    OP_IND_WR_D = 5'b01000,
    OP_DISP_WR  = 5'b01001,
    OP_DIR_WR   = 5'b01010,
    OP_PUSH     = 5'b01011,
    OP_POP      = 5'b01100,
    OP_IO_SET   = 5'b01101,
    OP_IO_CLR   = 5'b01110,
    OP_ROT_L    = 5'b01111,
    OP_ROT_R    = 5'b10000,
    OP_ASH_R    = 5'b10001,
    OP_BIT_TO_T = 5'b10010,
    OP_T_TO_BIT = 5'b10011,
    OP_V_SET    = 5'b10100,
    OP_V_CLR    = 5'b10101,
    OP_H_SET    = 5'b10110,
    OP_H_CLR    = 5'b10111,
    OP_S_SET    = 5'b11000,
    OP_S_CLR    = 5'b11001,
    OP_PMR_INC  = 5'b11010
  } lsbe_op_type;

  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } lsbe_ptr_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_MEM  = 1'b1
  } lsbe_state_type;

endpackage

// *** verif/lsbe_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Data memory and I/O space model.
// ----------------------------------------
module lsbe_mem_model
(
  // Clock.
  input  wire logic        clock,
  // Data memory.
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  output logic [7:0]       mem_rdata,
  // I/O space.
  input  wire logic [5:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic [7:0]  io_wmask,
  input  wire logic        io_we
);
  logic [7:0] mem [256];
  logic [7:0] io  [64];
  logic [7:0] last_q;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
    for (int i = 0; i < 64; i++)
      io[i] = 8'h81;
    last_q = 8'h00;
  end

  // Outside a read strobe the data lines show the inverse of the last value.
  assign mem_rdata = mem_re ? mem[mem_addr[7:0]] : ~last_q;

  always @(posedge clock)
  begin
    if (mem_re)
      last_q <= mem[mem_addr[7:0]];
    if (mem_we)
      mem[mem_addr[7:0]] <= mem_wdata;
    if (io_we)
      io[io_addr] <= (io[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
  end
endmodule // lsbe_mem_model
`default_nettype wire

// *** verif/lsbe_exec_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsbe_exec_bench
  import lsbe_pkg::*;
;
  logic clock, sys_rst, clk_en, op_valid, op_ready, op_error;
  lsbe_op_type op_code;
  logic [4:0]  op_reg;
  logic [1:0]  op_ptr;
  logic [5:0]  op_disp, op_io, io_addr;
  logic [15:0] op_addr, mem_addr;
  logic [2:0]  op_bit;
  logic [7:0]  mem_rdata, mem_wdata, io_wdata, io_wmask, sw_addr, sw_wdata, sw_rdata;
  logic        mem_we, mem_re, io_we, sw_write, sw_read;
  int          n_fail;
  int          check_count;
  lsbe_op_type set_ops [3] = '{OP_V_SET, OP_H_SET, OP_S_SET};
  lsbe_op_type clr_ops [3] = '{OP_V_CLR, OP_H_CLR, OP_S_CLR};
  int          flag_pos [3] = '{FLAG_V, FLAG_H, FLAG_S};

  lsbe_exec u_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_reg(op_reg), .op_ptr(op_ptr), .op_disp(op_disp), .op_addr(op_addr),
    .op_bit(op_bit), .op_io(op_io), .op_ready(op_ready), .op_error(op_error),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .io_addr(io_addr), .io_wdata(io_wdata), .io_wmask(io_wmask), .io_we(io_we),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
    .sw_rdata(sw_rdata));

  lsbe_mem_model u_mem (.clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wmask(io_wmask), .io_we(io_we));

  // ----------------------------------------
  // Clock, reset and watchdog.
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sw_write <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_write <= 1'b0;
  endtask

  task automatic sw_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sw_read <= 1'b1;
    sw_addr <= a;
    @(posedge clock);
    sw_read <= 1'b0;
    #1;
    chk(sw_rdata, exp);
  endtask

  // Issues one operation and checks its cycle count through op_ready.
  task automatic op(input lsbe_op_type c, input logic [4:0] r, input logic [1:0] p,
                    input logic [15:0] a, input logic two);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code  <= c;
    op_reg   <= r;
    op_ptr   <= p;
    op_disp  <= a[5:0];
    op_addr  <= a;
    op_bit   <= a[2:0];
    op_io    <= a[13:8];
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    chk(op_ready, !two);
    if (two)
    begin
      @(posedge clock);
      #1;
      chk(op_ready, 1'b1);
    end
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_loads();
    sw_wr(8'h1c, 8'hff);
    sw_wr(8'h1d, 8'h00);
    sw_wr(8'h1e, 8'h00);
    sw_wr(8'h1f, 8'h01);
    op(OP_IND_RD_I, 5'd5, PTR_Y, 16'h0000, 1'b1);
    sw_rd(8'h05, 8'h5a);
    sw_rd(8'h1c, 8'h00);
    sw_rd(8'h1d, 8'h01);
    op(OP_IND_RD_D, 5'd6, PTR_Z, 16'h0000, 1'b1);
    sw_rd(8'h06, 8'h5a);
    sw_rd(8'h1e, 8'hff);
    sw_rd(8'h1f, 8'h00);
    op(OP_DISP_RD, 5'd7, PTR_Y, 16'h0005, 1'b1);
    sw_rd(8'h07, 8'ha0);
    sw_rd(8'h1c, 8'h00);
    op(OP_DIR_RD, 5'd8, PTR_X, 16'h0042, 1'b1);
    sw_rd(8'h08, 8'he7);
    sw_rd(8'h20, 8'h00);
  endtask

  task automatic t_stores();
    sw_wr(8'h1a, 8'h10);
    sw_wr(8'h1b, 8'h00);
    sw_wr(8'h01, 8'h3c);
    sw_wr(8'h02, 8'hc3);
    op(OP_IND_WR_I, 5'd1, PTR_X, 16'h0000, 1'b1);
    chk(u_mem.mem[8'h10], 8'h3c);
    sw_rd(8'h1a, 8'h11);
    op(OP_IND_WR_D, 5'd2, PTR_X, 16'h0000, 1'b1);
    chk(u_mem.mem[8'h10], 8'hc3);
    sw_rd(8'h1a, 8'h10);
    op(OP_DISP_WR, 5'd1, PTR_Z, 16'h0003, 1'b1);
    chk(u_mem.mem[8'h02], 8'h3c);
    sw_rd(8'h1e, 8'hff);
    op(OP_DIR_WR, 5'd2, PTR_X, 16'h0080, 1'b1);
    chk(u_mem.mem[8'h80], 8'hc3);
    sw_rd(8'h20, 8'h00);
  endtask

  task automatic t_stack_io();
    op(OP_PUSH, 5'd1, PTR_X, 16'h0000, 1'b1);
    chk(u_mem.mem[8'h7f], 8'h3c);
    sw_rd(8'h21, 8'h7e);
    op(OP_POP, 5'd9, PTR_X, 16'h0000, 1'b1);
    sw_rd(8'h09, 8'h3c);
    sw_rd(8'h21, 8'h7f);
    sw_rd(8'h20, 8'h00);
    op(OP_IO_SET, 5'd0, PTR_X, 16'h0304, 1'b1);
    chk(u_mem.io[3], 8'h91);
    op(OP_IO_CLR, 5'd0, PTR_X, 16'h0307, 1'b1);
    chk(u_mem.io[3], 8'h11);
  endtask

  task automatic t_bits();
    sw_wr(8'h0a, 8'h80);
    op(OP_ROT_L, 5'd10, PTR_X, 16'h0000, 1'b0);
    sw_rd(8'h0a, 8'h00);
    sw_rd(8'h20, 8'h0b);
    op(OP_ROT_R, 5'd10, PTR_X, 16'h0000, 1'b0);
    sw_rd(8'h0a, 8'h80);
    sw_rd(8'h20, 8'h0c);
    sw_wr(8'h20, 8'h00);
    sw_wr(8'h0b, 8'h81);
    op(OP_ASH_R, 5'd11, PTR_X, 16'h0000, 1'b0);
    sw_rd(8'h0b, 8'hc0);
    sw_rd(8'h20, 8'h05);
    sw_wr(8'h20, 8'h00);
    sw_wr(8'h0c, 8'h08);
    op(OP_BIT_TO_T, 5'd12, PTR_X, 16'h0003, 1'b0);
    sw_rd(8'h20, 8'h40);
    op(OP_T_TO_BIT, 5'd13, PTR_X, 16'h0006, 1'b0);
    sw_rd(8'h0d, 8'h40);
    sw_rd(8'h20, 8'h40);
  endtask

  task automatic t_flags();
    sw_wr(8'h20, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      op(set_ops[i], 5'd0, PTR_X, 16'h0000, 1'b0);
      sw_rd(8'h20, 8'h01 << flag_pos[i]);
      op(clr_ops[i], 5'd0, PTR_X, 16'h0000, 1'b0);
      sw_rd(8'h20, 8'h00);
    end
    op(OP_PMR_INC, 5'd0, PTR_Z, 16'h0000, 1'b0);
    chk(op_error, 1'b1);
    sw_rd(8'h23, 8'h02);
  endtask

  // Plain indirect forms, error clear, both enables and a reset in mid-run.
  task automatic t_misc();
    op(OP_IND_WR, 5'd1, PTR_X, 16'h0000, 1'b1);
    chk(u_mem.mem[8'h10], 8'h3c);
    op(OP_IND_RD, 5'd14, PTR_X, 16'h0000, 1'b1);
    sw_rd(8'h0e, 8'h3c);
    sw_rd(8'h1a, 8'h10);
    sw_wr(8'h23, 8'h02);
    sw_rd(8'h23, 8'h00);
    sw_wr(8'h24, 8'h00);
    op(OP_V_SET, 5'd0, PTR_X, 16'h0000, 1'b0);
    sw_rd(8'h20, 8'h00);
    sw_wr(8'h24, 8'h01);
    @(posedge clock);
    clk_en <= 1'b0;
    op(OP_S_SET, 5'd0, PTR_X, 16'h0000, 1'b0);
    @(posedge clock);
    clk_en <= 1'b1;
    sw_rd(8'h20, 8'h00);
    op(OP_H_SET, 5'd0, PTR_X, 16'h0000, 1'b0);
    op(OP_PMR_INC, 5'd0, PTR_Z, 16'h0000, 1'b0);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    chk(op_error, 1'b0);
    sw_rd(8'h20, 8'h00);
    sw_rd(8'h21, 8'h7f);
  endtask

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    n_fail = 0;
    check_count = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    op_valid = 1'b0;
    op_code = OP_NOP;
    op_reg = 5'd0;
    op_ptr = PTR_X;
    op_disp = 6'h00;
    op_addr = 16'h0000;
    op_bit = 3'd0;
    op_io = 6'h00;
    sw_addr = 8'h00;
    sw_wdata = 8'h00;
    sw_write = 1'b0;
    sw_read = 1'b0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    sw_rd(8'h20, 8'h00);
    sw_rd(8'h21, 8'h7f);
    sw_rd(8'h22, 8'h00);
    sw_rd(8'h24, 8'h01);
    t_loads();
    t_stores();
    t_stack_io();
    t_bits();
    t_flags();
    t_misc();
    end_of_test();
  end
endmodule // lsbe_exec_bench
`default_nettype wire
